// ---- dlpc_pkg.sv ----
package dlpc_pkg;

	// ****************************************************************
	// Power-down selector encodings
	// ****************************************************************
	localparam logic [1:0] PD_NORMAL  = 2'h0;
	localparam logic [1:0] PD_PULL_1K = 2'h1;
	localparam logic [1:0] PD_PULL_100K = 2'h2;
	localparam logic [1:0] PD_OPEN    = 2'h3;

	// ****************************************************************
	// Reference selector encodings
	// ****************************************************************
	localparam logic [1:0] REF_SUPPLY   = 2'h0;
	localparam logic [1:0] REF_BANDGAP  = 2'h1;
	localparam logic [1:0] REF_PIN_UNBUF = 2'h2;
	localparam logic [1:0] REF_PIN_BUF  = 2'h3;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS     = 50;
	localparam int ENTRY_DELAY_NS    = 1000;
	localparam int EXIT_DELAY_NS     = 2000;
	localparam int ENTRY_DELAY_CYC   = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_DELAY_CYC    = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DELAY_CNT_W       = 16;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [1:0] PD_RESET   = 2'h0;

	// ****************************************************************
	// Output stage states
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_DRIVE    = 2'b00,
		ST_ENTERING = 2'b01,
		ST_DOWN     = 2'b10,
		ST_EXITING  = 2'b11
	} dlpc_out_state_t;

endpackage : dlpc_pkg

// ---- dlpc_channel_pwr.sv ----
`timescale 1ns/1ns
// ****************************************************************
// One channel: power-down sequencing and current consumers
// ****************************************************************
module dlpc_channel_pwr #(
	parameter int ENTRY_CYC = dlpc_pkg::ENTRY_DELAY_CYC,
	parameter int EXIT_CYC  = dlpc_pkg::EXIT_DELAY_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [1:0] powerdown_select,
	input  wire logic [1:0] reference_select,
	output logic            amp_drive,
	output logic            pull_1k_en,
	output logic            pull_100k_en,
	output logic            amp_power,
	output logic            ladder_from_supply,
	output logic            ladder_from_pin,
	output logic            ref_buffer_en,
	output logic            bandgap_en,
	output logic            in_powerdown
);

	localparam logic [dlpc_pkg::DELAY_CNT_W-1:0] ENTRY_N =
		dlpc_pkg::DELAY_CNT_W'(ENTRY_CYC);
	localparam logic [dlpc_pkg::DELAY_CNT_W-1:0] EXIT_N =
		dlpc_pkg::DELAY_CNT_W'(EXIT_CYC);

	dlpc_pkg::dlpc_out_state_t         state;
	dlpc_pkg::dlpc_out_state_t         next_state;
	logic [dlpc_pkg::DELAY_CNT_W-1:0]  cnt;
	logic [dlpc_pkg::DELAY_CNT_W-1:0]  next_cnt;
	logic [1:0]                        held_mode;
	logic [1:0]                        next_held_mode;
	logic                              pd_req;

	assign pd_req = (powerdown_select != dlpc_pkg::PD_NORMAL);

	// ****************************************************************
	// Entry and exit sequencing
	// ****************************************************************
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_held_mode = held_mode;
		case (state)
			dlpc_pkg::ST_DRIVE: begin
				if (pd_req) begin
					next_state = dlpc_pkg::ST_ENTERING;
					next_cnt   = ENTRY_N - 1'b1;
				end
			end
			dlpc_pkg::ST_ENTERING: begin
				if (!pd_req) begin
					next_state = dlpc_pkg::ST_DRIVE;
				end else if (cnt == '0) begin
					next_state     = dlpc_pkg::ST_DOWN;
					next_held_mode = powerdown_select;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			dlpc_pkg::ST_DOWN: begin
				next_held_mode = powerdown_select;
				if (!pd_req) begin
					next_state = dlpc_pkg::ST_EXITING;
					next_cnt   = EXIT_N - 1'b1;
				end
			end
			dlpc_pkg::ST_EXITING: begin
				if (pd_req) begin
					next_state     = dlpc_pkg::ST_DOWN;
					next_held_mode = powerdown_select;
				end else if (cnt == '0) begin
					next_state = dlpc_pkg::ST_DRIVE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = dlpc_pkg::ST_DRIVE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state     <= dlpc_pkg::ST_DRIVE;
			cnt       <= '0;
			held_mode <= dlpc_pkg::PD_RESET;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			held_mode <= next_held_mode;
		end
	end

	// ****************************************************************
	// Output stage and current consumers
	// ****************************************************************
	// amplifier off, output high impedance
	assign amp_drive    = (state == dlpc_pkg::ST_DRIVE) || (state == dlpc_pkg::ST_ENTERING);
	assign in_powerdown = !amp_drive;
	// Pull-down let go as soon as normal mode is asked for
	// pull-down decode
	assign pull_1k_en   = (state == dlpc_pkg::ST_DOWN) && pd_req &&
		(held_mode == dlpc_pkg::PD_PULL_1K);
	assign pull_100k_en = (state == dlpc_pkg::ST_DOWN) && pd_req &&
		(held_mode == dlpc_pkg::PD_PULL_100K);

	assign amp_power          = !pd_req;
	assign ladder_from_supply = !pd_req && (reference_select != dlpc_pkg::REF_PIN_UNBUF);
	assign ladder_from_pin    = !pd_req && (reference_select == dlpc_pkg::REF_PIN_UNBUF);
	assign ref_buffer_en      = !pd_req && (reference_select == dlpc_pkg::REF_BANDGAP ||
		reference_select == dlpc_pkg::REF_PIN_BUF);
	assign bandgap_en         = (reference_select == dlpc_pkg::REF_BANDGAP);

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_entry_delay_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == dlpc_pkg::ST_DRIVE && pd_req) |=> amp_drive)
		else $error("output stopped driving before entry delay");

	a_pulldown_only_down: assert property (@(posedge mclk) disable iff (!rst_n)
		(pull_1k_en || pull_100k_en) |-> !amp_drive && pd_req)
		else $error("pull-down enabled while driving");

	a_exit_delay_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == dlpc_pkg::ST_DOWN && !pd_req) |=> !amp_drive)
		else $error("output driving before exit delay");

	a_bandgap_down: assert property (@(posedge mclk) disable iff (!rst_n)
		pd_req |-> (bandgap_en == (reference_select == dlpc_pkg::REF_BANDGAP))
		&& !ref_buffer_en && !amp_power)
		else $error("consumer left on in power-down");

	a_consumers_normal: assert property (@(posedge mclk) disable iff (!rst_n)
		!pd_req |-> amp_power && (ladder_from_pin != ladder_from_supply)
		&& (ref_buffer_en == reference_select[0]))
		else $error("consumer wrong in normal mode");

endmodule : dlpc_channel_pwr

// ---- dlpc_ctrl.sv ----
`timescale 1ns/1ns
// What this block does
// - Gate high blocks copying code to output; register writes still accepted.
// - Gate low copies each code register to its output continuously.
// - Gate pin is asynchronous and passes a two-flop synchroniser.
// - All channels on one gate update together when it falls.
// - Each channel has its own power-down selector and state.
// - Selector 00 normal, 01 1k pull-down, 10 100k pull-down, 11 open.
// - Power-down turns off amplifier, output pulled down (01, 10) or floats (11), registers kept.
// - Entering power-down waits the entry delay before output stops.
// - Selector changes only by register write, wake-up, general call reset or reset load from store.
// - Selector updated by write, general call reset, general call wake-up.
// - Command interface stays active during any power-down.
// - General call reset loads code and reference from nonvolatile values, clears selector.
// - Normal mode powers amplifier, ladder source and buffer per reference.
// - Power-down turns off amplifier, ladder, buffer; band gap stays on only for reference 01.
// - Write of 00, wake-up or general call reset returns selector to normal.
// - Leaving power-down waits the exit delay before output drives.
module dlpc_ctrl #(
	parameter int CODE_W    = 12,
	parameter int CHANNELS  = 2,
	parameter int ENTRY_CYC = dlpc_pkg::ENTRY_DELAY_CYC,
	parameter int EXIT_CYC  = dlpc_pkg::EXIT_DELAY_CYC
) (
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	input  wire logic                       wiper_transfer_gate,
	input  wire logic                       code_wr,
	input  wire logic [CHANNELS-1:0]        code_wr_sel,
	input  wire logic [CODE_W-1:0]          code_wr_data,
	input  wire logic                       pd_wr,
	input  wire logic [CHANNELS-1:0]        pd_wr_sel,
	input  wire logic [1:0]                 pd_wr_data,
	input  wire logic                       ref_wr,
	input  wire logic [CHANNELS-1:0]        ref_wr_sel,
	input  wire logic [1:0]                 ref_wr_data,
	input  wire logic                       gc_reset,
	input  wire logic                       gc_wakeup,
	input  wire logic [CHANNELS*CODE_W-1:0] nv_code,
	input  wire logic [CHANNELS*2-1:0]      nv_powerdown_select,
	input  wire logic [CHANNELS*2-1:0]      nv_reference_select,
	output logic [CHANNELS*CODE_W-1:0]      volatile_code,
	output logic [CHANNELS*CODE_W-1:0]      output_code,
	output logic [CHANNELS*2-1:0]           powerdown_select,
	output logic [CHANNELS*2-1:0]           reference_select,
	output logic [CHANNELS-1:0]             amp_drive,
	output logic [CHANNELS-1:0]             pull_1k_en,
	output logic [CHANNELS-1:0]             pull_100k_en,
	output logic [CHANNELS-1:0]             amp_power,
	output logic [CHANNELS-1:0]             ladder_from_supply,
	output logic [CHANNELS-1:0]             ladder_from_pin,
	output logic [CHANNELS-1:0]             ref_buffer_en,
	output logic [CHANNELS-1:0]             bandgap_en,
	output logic                            all_powered_down,
	output logic                            cmd_ready
);

	// ****************************************************************
	// Gate synchroniser
	// ****************************************************************
	logic gate_meta;
	logic gate_sync;
	logic gate_prev;
	logic next_gate_meta;
	logic next_gate_sync;
	logic next_gate_prev;

	always_comb begin
		next_gate_meta = wiper_transfer_gate;
		next_gate_sync = gate_meta;
		next_gate_prev = gate_sync;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gate_meta <= 1'b1;
			gate_sync <= 1'b1;
			gate_prev <= 1'b1;
		end else begin
			gate_meta <= next_gate_meta;
			gate_sync <= next_gate_sync;
			gate_prev <= next_gate_prev;
		end
	end

	// ****************************************************************
	// Volatile registers
	// ****************************************************************
	logic [CHANNELS*CODE_W-1:0] next_volatile_code;
	logic [CHANNELS*CODE_W-1:0] next_output_code;
	logic [CHANNELS*2-1:0]      next_powerdown_select;
	logic [CHANNELS*2-1:0]      next_reference_select;
	logic [CHANNELS-1:0]        in_pd;
	logic                       loaded;
	logic                       next_loaded;

	always_comb begin
		next_volatile_code    = volatile_code;
		next_powerdown_select = powerdown_select;
		next_reference_select = reference_select;
		next_loaded           = 1'b1;
		// general call reset reloads code and reference from nonvolatile values
		// power-on load path loads selector from nonvolatile store; general call reset clears it
		if (gc_reset || !loaded) begin
			next_volatile_code    = nv_code;
			next_powerdown_select = nv_powerdown_select;
			next_reference_select = nv_reference_select;
			if (gc_reset) begin
				next_powerdown_select = '0;
			end
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (code_wr && code_wr_sel[c]) begin
					next_volatile_code[c*CODE_W +: CODE_W] = code_wr_data;
				end
				if (pd_wr && pd_wr_sel[c]) begin
					next_powerdown_select[c*2 +: 2] = pd_wr_data;
				end
				if (ref_wr && ref_wr_sel[c]) begin
					next_reference_select[c*2 +: 2] = ref_wr_data;
				end
				if (gc_wakeup) begin
					next_powerdown_select[c*2 +: 2] = dlpc_pkg::PD_NORMAL;
				end
			end
		end
	end

	// all channels share the synchronised gate
	always_comb begin
		if (gate_sync) begin
			next_output_code = output_code;
		end else begin
			next_output_code = volatile_code;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			volatile_code    <= '0;
			output_code      <= '0;
			powerdown_select <= '0;
			reference_select <= '0;
			loaded           <= 1'b0;
		end else begin
			volatile_code    <= next_volatile_code;
			output_code      <= next_output_code;
			powerdown_select <= next_powerdown_select;
			reference_select <= next_reference_select;
			loaded           <= next_loaded;
		end
	end

	// command port never gated by power-down
	assign cmd_ready        = loaded;
	// flag lets the host avoid nonvolatile writes
	assign all_powered_down = &in_pd;

	// ****************************************************************
	// Per-channel power sequencing
	// ****************************************************************
	for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
		dlpc_channel_pwr #(
			.ENTRY_CYC (ENTRY_CYC),
			.EXIT_CYC  (EXIT_CYC)
		) u_pwr (
			.mclk               (mclk),
			.rst_n              (rst_n),
			.powerdown_select   (powerdown_select[g*2 +: 2]),
			.reference_select   (reference_select[g*2 +: 2]),
			.amp_drive          (amp_drive[g]),
			.pull_1k_en         (pull_1k_en[g]),
			.pull_100k_en       (pull_100k_en[g]),
			.amp_power          (amp_power[g]),
			.ladder_from_supply (ladder_from_supply[g]),
			.ladder_from_pin    (ladder_from_pin[g]),
			.ref_buffer_en      (ref_buffer_en[g]),
			.bandgap_en         (bandgap_en[g]),
			.in_powerdown       (in_pd[g])
		);
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_gate_blocks_copy: assert property (@(posedge mclk) disable iff (!rst_n)
		gate_sync |=> $stable(output_code))
		else $error("output code changed while gate high");

	a_gate_low_copies: assert property (@(posedge mclk) disable iff (!rst_n)
		!gate_sync |=> output_code == $past(volatile_code))
		else $error("output code not copied while gate low");

	a_sync_latency: assert property (@(posedge mclk) disable iff (!rst_n)
		(gate_prev && !gate_sync) |=> output_code == $past(volatile_code))
		else $error("channels not updated together on gate fall");

	a_wakeup_normal: assert property (@(posedge mclk) disable iff (!rst_n)
		(gc_wakeup && !gc_reset && loaded) |=> powerdown_select == '0)
		else $error("wake-up did not clear selector");

	a_gc_reset_load: assert property (@(posedge mclk) disable iff (!rst_n)
		gc_reset |=> volatile_code == $past(nv_code)
		&& reference_select == $past(nv_reference_select))
		else $error("general call reset did not load stored values");

	a_pd_change_cause: assert property (@(posedge mclk) disable iff (!rst_n)
		(loaded && !gc_reset && !gc_wakeup && !pd_wr) |=> $stable(powerdown_select))
		else $error("selector changed without a command");

	a_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
		(loaded && !gc_reset && code_wr && code_wr_sel[0])
		|=> volatile_code[CODE_W-1:0] == $past(code_wr_data))
		else $error("code write did not land");

	a_code_retained: assert property (@(posedge mclk) disable iff (!rst_n)
		(loaded && !gc_reset && !code_wr) |=> $stable(volatile_code))
		else $error("code register changed without a write");

	a_pd_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
		(loaded && !gc_reset && !gc_wakeup && pd_wr && pd_wr_sel[0])
		|=> powerdown_select[1:0] == $past(pd_wr_data))
		else $error("selector write did not land");

	a_gc_reset_wakes: assert property (@(posedge mclk) disable iff (!rst_n)
		gc_reset |=> powerdown_select == '0)
		else $error("general call reset left a channel powered down");

	a_power_on_load: assert property (@(posedge mclk) disable iff (!rst_n)
		(!loaded && !gc_reset) |=> powerdown_select == $past(nv_powerdown_select))
		else $error("selector not loaded from store after reset");

	a_channels_apart: assert property (@(posedge mclk) disable iff (!rst_n)
		(loaded && !gc_reset && !gc_wakeup && !(pd_wr && pd_wr_sel[CHANNELS-1]))
		|=> $stable(powerdown_select[CHANNELS*2-1 -: 2]))
		else $error("selector of unaddressed channel changed");

endmodule : dlpc_ctrl

// ---- dlpc_partner.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Host and latch logic model
// ****************************************************************
module dlpc_partner #(
	parameter int CODE_W = 12
) (
	input  wire logic        mclk,
	output logic             wiper_transfer_gate,
	output logic             code_wr,
	output logic [1:0]       code_wr_sel,
	output logic [CODE_W-1:0] code_wr_data,
	output logic             pd_wr,
	output logic [1:0]       pd_wr_sel,
	output logic [1:0]       pd_wr_data,
	output logic             ref_wr,
	output logic [1:0]       ref_wr_sel,
	output logic [1:0]       ref_wr_data,
	output logic             gc_reset,
	output logic             gc_wakeup
);
	initial begin
		wiper_transfer_gate = 1'b0;
		{code_wr, pd_wr, ref_wr, gc_reset, gc_wakeup} = 5'h00;
		{code_wr_sel, pd_wr_sel, ref_wr_sel} = 6'h00;
		code_wr_data = '0;
		{pd_wr_data, ref_wr_data} = 4'h0;
	end

	// Kind 0 code, 1 power-down, 2 reference, 3 reset, 4 wake-up
	task automatic wr(input int kind, input logic [1:0] sel, input logic [CODE_W-1:0] d);
		@(posedge mclk);
		case (kind)
			0: begin
				code_wr <= 1'b1;
				code_wr_sel <= sel;
				code_wr_data <= d;
			end
			1: begin
				pd_wr <= 1'b1;
				pd_wr_sel <= sel;
				pd_wr_data <= d[1:0];
			end
			2: begin
				ref_wr <= 1'b1;
				ref_wr_sel <= sel;
				ref_wr_data <= d[1:0];
			end
			3: gc_reset <= 1'b1;
			default: gc_wakeup <= 1'b1;
		endcase
		@(posedge mclk);
		{code_wr, pd_wr, ref_wr, gc_reset, gc_wakeup} <= 5'h00;
		// Released buses carry junk
		code_wr_data <= ~d;
		pd_wr_data <= ~d[1:0];
		ref_wr_data <= ~d[1:0];
	endtask : wr

	// Gate moves mid-cycle, unrelated to writes
	task automatic set_gate(input logic v);
		@(negedge mclk);
		#7;
		wiper_transfer_gate = v;
	endtask : set_gate
endmodule : dlpc_partner

// ---- dlpc_ctrl_tb_top.sv ----
`timescale 1ns/1ns
module dlpc_ctrl_tb_top;
	localparam int ENT = 2;
	localparam int EXT = 3;
	typedef struct packed {
		logic [1:0] rf;
		logic [1:0] pd;
		logic [4:0] pwr;
		logic [2:0] out;
	} dlpc_row_t;
	logic        mclk, rst_n, wiper_transfer_gate, code_wr, pd_wr, ref_wr, gc_reset, gc_wakeup;
	logic [1:0]  code_wr_sel, pd_wr_sel, pd_wr_data, ref_wr_sel, ref_wr_data;
	logic [11:0] code_wr_data;
	logic [23:0] nv_code, volatile_code, output_code;
	logic [3:0]  nv_powerdown_select, nv_reference_select, powerdown_select, reference_select;
	logic [1:0]  amp_drive, pull_1k_en, pull_100k_en, amp_power, ladder_from_supply;
	logic [1:0]  ladder_from_pin, ref_buffer_en, bandgap_en;
	logic        all_powered_down, cmd_ready;
	int          err_total, checks_done, n, drops;
	dlpc_row_t   rows [8];

	dlpc_ctrl #(.ENTRY_CYC(ENT), .EXIT_CYC(EXT)) uut (.mclk, .rst_n, .wiper_transfer_gate,
		.code_wr, .code_wr_sel, .code_wr_data, .pd_wr, .pd_wr_sel, .pd_wr_data, .ref_wr,
		.ref_wr_sel, .ref_wr_data, .gc_reset, .gc_wakeup, .nv_code, .nv_powerdown_select,
		.nv_reference_select, .volatile_code, .output_code, .powerdown_select,
		.reference_select, .amp_drive, .pull_1k_en, .pull_100k_en, .amp_power,
		.ladder_from_supply, .ladder_from_pin, .ref_buffer_en, .bandgap_en,
		.all_powered_down, .cmd_ready);
	dlpc_partner host (.mclk, .wiper_transfer_gate, .code_wr, .code_wr_sel, .code_wr_data,
		.pd_wr, .pd_wr_sel, .pd_wr_data, .ref_wr, .ref_wr_sel, .ref_wr_data, .gc_reset,
		.gc_wakeup);

	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	// ****************************************************************
	// Compare and closing tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic chk_cnt(input string nm, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", nm, exp, got);
		end
	endtask : chk_cnt
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_drive(input logic lvl, output int k);
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (amp_drive[0] !== lvl && k < 60);
	endtask : wait_drive

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		// Reference, selector, {amp, sup, pin, buf, bg}, {drive, 1k, 100k}
		rows = '{'{2'h0, 2'h0, 5'h18, 3'h4}, '{2'h1, 2'h0, 5'h1B, 3'h4},
			'{2'h2, 2'h0, 5'h14, 3'h4}, '{2'h3, 2'h0, 5'h1A, 3'h4},
			'{2'h0, 2'h1, 5'h00, 3'h2}, '{2'h1, 2'h2, 5'h01, 3'h1},
			'{2'h2, 2'h3, 5'h00, 3'h0}, '{2'h3, 2'h1, 5'h00, 3'h2}};
		err_total = 0;
		checks_done = 0;
		rst_n = 1'b0;
		nv_code = {12'h3C5, 12'h9A1};
		nv_powerdown_select = {dlpc_pkg::PD_NORMAL, dlpc_pkg::PD_OPEN};
		nv_reference_select = {dlpc_pkg::REF_PIN_BUF, dlpc_pkg::REF_BANDGAP};
		repeat (5) @(posedge mclk);
		#1;
		chk("drive in reset", 24'h3, {22'h0, amp_drive});
		chk("ready in reset", 24'h0, {23'h0, cmd_ready});
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("cmd_ready", 24'h1, {23'h0, cmd_ready});
		chk("volatile_code", nv_code, volatile_code);
		chk("pd load", {20'h0, nv_powerdown_select}, {20'h0, powerdown_select});
		chk("ref load", {20'h0, nv_reference_select}, {20'h0, reference_select});

		foreach (rows[i]) begin
			host.wr(2, 2'h1, {10'h0, rows[i].rf});
			host.wr(1, 2'h1, {10'h0, rows[i].pd});
			@(negedge mclk);
			chk("consumers", {19'h0, rows[i].pwr}, {19'h0, amp_power[0], ladder_from_supply[0],
				ladder_from_pin[0], ref_buffer_en[0], bandgap_en[0]});
			repeat (ENT + EXT + 4) @(negedge mclk);
			chk("output stage", {21'h0, rows[i].out},
				{21'h0, amp_drive[0], pull_1k_en[0], pull_100k_en[0]});
			chk("other channel", 24'h1, {23'h0, amp_drive[1]});
		end

		// Entry and exit delays
		host.wr(1, 2'h1, {10'h0, dlpc_pkg::PD_NORMAL});
		repeat (EXT + 4) @(posedge mclk);
		host.wr(1, 2'h1, {10'h0, dlpc_pkg::PD_PULL_1K});
		wait_drive(1'b0, n);
		chk_cnt("entry cycles", ENT + 1, n);
		chk("pull with drop", 24'h1, {23'h0, pull_1k_en[0]});
		host.wr(1, 2'h1, {10'h0, dlpc_pkg::PD_NORMAL});
		wait_drive(1'b1, n);
		chk_cnt("exit cycles", EXT + 1, n);
		// Entry aborted by immediate return to normal
		repeat (2) @(posedge mclk);
		host.wr(1, 2'h1, {10'h0, dlpc_pkg::PD_PULL_100K});
		host.wr(1, 2'h1, {10'h0, dlpc_pkg::PD_NORMAL});
		drops = 0;
		repeat (8) begin
			@(posedge mclk);
			#1;
			if (amp_drive[0] !== 1'b1)
				drops++;
		end
		chk_cnt("aborted entry", 0, drops);

		// Gate holds, then both channels update together
		host.set_gate(1'b1);
		host.wr(0, 2'h3, 12'hA5C);
		repeat (4) @(negedge mclk);
		chk("code while held", {12'hA5C, 12'hA5C}, volatile_code);
		chk("output held", nv_code, output_code);
		host.set_gate(1'b0);
		repeat (2) @(posedge mclk);
		#1;
		chk("output before sync", nv_code, output_code);
		@(posedge mclk);
		#1;
		chk("joint update", {12'hA5C, 12'hA5C}, output_code);
		host.wr(0, 2'h1, 12'h123);
		#1;
		chk("copy lag", {12'hA5C, 12'hA5C}, output_code);
		@(posedge mclk);
		#1;
		chk("copy level", {12'hA5C, 12'h123}, output_code);

		// Both down, commands still taken, wake-up and reset
		host.wr(1, 2'h1, {10'h0, dlpc_pkg::PD_OPEN});
		host.wr(1, 2'h2, {10'h0, dlpc_pkg::PD_PULL_100K});
		repeat (ENT + 4) @(negedge mclk);
		chk("all down", 24'h1, {23'h0, all_powered_down});
		chk("ready in pd", 24'h1, {23'h0, cmd_ready});
		chk("ch1 pull", 24'h1, {22'h0, pull_1k_en[1], pull_100k_en[1]});
		chk("ch1 consumers", 24'h0, {22'h0, amp_power[1], ref_buffer_en[1]});
		host.wr(0, 2'h3, 12'h0F0);
		@(negedge mclk);
		chk("write in pd", {12'h0F0, 12'h0F0}, volatile_code);
		chk("pd kept", 24'hB, {20'h0, powerdown_select});
		host.wr(4, 2'h0, 12'h0);
		@(negedge mclk);
		chk("wake-up", 24'h0, {20'h0, powerdown_select});
		repeat (EXT + 3) @(negedge mclk);
		chk("driving again", 24'h3, {22'h0, amp_drive});
		chk("not all down", 24'h0, {23'h0, all_powered_down});
		host.wr(1, 2'h3, {10'h0, dlpc_pkg::PD_PULL_1K});
		host.wr(2, 2'h3, {10'h0, dlpc_pkg::REF_SUPPLY});
		host.wr(3, 2'h0, 12'h0);
		@(negedge mclk);
		chk("gc pd", 24'h0, {20'h0, powerdown_select});
		chk("gc code", nv_code, volatile_code);
		chk("gc ref", {20'h0, nv_reference_select}, {20'h0, reference_select});
		tally_and_finish();
	end
endmodule : dlpc_ctrl_tb_top
